// file: dv/serial_peer_model.sv
// Model of the serial peer and board wiring on the shared pins
`timescale 1ns/100ps
module serial_peer_model (
   // Clock
   input wire logic clock,
   // Device pins
   input wire logic [2:0] pinOut,
   input wire logic [2:0] pinOe,
   input wire logic [2:0] pulldownOn,
   // Peer drive request from the bench
   input wire logic [2:0] peerDrive,
   input wire logic [2:0] peerLevel,
   output logic [2:0] pinIn
);
   logic floatLevel;
   initial floatLevel = 1'b0;
   always @(posedge clock) floatLevel <= ~floatLevel;
   // Undriven pin without pulldown toggles its level on every clock
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         if (pinOe[i]) pinIn[i] = pinOut[i];
         else if (peerDrive[i]) pinIn[i] = peerLevel[i];
         else if (pulldownOn[i]) pinIn[i] = 1'b0;
         else pinIn[i] = floatLevel;
      end
   end
endmodule

// file: dv/tb_port_b_serial_pin_mux.sv
// Self-checking bench for the shared port pin multiplexer
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
$display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_port_b_serial_pin_mux;
   localparam logic [1:0] AD = port_b_serial_pin_mux_pkg::ADDR_DATA;
   localparam logic [1:0] AR = port_b_serial_pin_mux_pkg::ADDR_DIRECTION;
   localparam logic [1:0] AI = port_b_serial_pin_mux_pkg::ADDR_PULLDOWN_INHIBIT;
   localparam logic [1:0] AC = port_b_serial_pin_mux_pkg::ADDR_SERIAL_CONTROL;
   logic clock, rst, clockEnable, writeStrobe, readStrobe, globalPulldownDisable;
   logic serialDataOutShift, serialClockGenerated, serialDataInShift, serialClockIn;
   logic serialEnableBit, masterSelectBit;
   logic [1:0] address;
   logic [7:0] writeData, readData;
   logic [2:0] pinIn, pinOut, pinOe, pulldownOn, peerDrive, peerLevel;
   int err_total = 0, check_count = 0, cycles = 0;
   port_b_serial_pin_mux port_b_serial_pin_mux_inst (.clock, .rst, .clockEnable, .address,
      .writeData, .writeStrobe, .readStrobe, .readData, .globalPulldownDisable,
      .serialDataOutShift, .serialClockGenerated, .serialDataInShift, .serialClockIn,
      .serialEnableBit, .masterSelectBit, .pinIn, .pinOut, .pinOe, .pulldownOn);
   serial_peer_model serial_peer_model_inst (.clock, .pinOut, .pinOe, .pulldownOn,
      .peerDrive, .peerLevel, .pinIn);
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clock);
      address <= a;
      writeData <= d;
      writeStrobe <= 1'b1;
      @(posedge clock);
      writeStrobe <= 1'b0;
      @(negedge clock);
   endtask
   task automatic rd(input logic [1:0] a, input logic [2:0] e, input string n);
      @(posedge clock);
      address <= a;
      readStrobe <= 1'b1;
      @(posedge clock);
      readStrobe <= 1'b0;
      @(negedge clock);
      `CHK(n, e, readData[2:0])
   endtask
   task automatic pins(input logic [2:0] oe, input logic [2:0] o, input logic [2:0] pd);
      `CHK("pinOe", oe, pinOe)
      `CHK("pinOut", o, pinOut)
      `CHK("pulldownOn", pd, pulldownOn)
   endtask
   task automatic t_plain();
      rd(AR, 3'h0, "direction");
      pins(3'h0, 3'h0, 3'h7);
      wr(AI, 8'h02);
      pins(3'h0, 3'h0, 3'h5);
      rd(AI, 3'h2, "inhibit");
      @(posedge clock);
      globalPulldownDisable <= 1'b1;
      @(negedge clock);
      pins(3'h0, 3'h0, 3'h0);
      @(posedge clock);
      globalPulldownDisable <= 1'b0;
      wr(AD, 8'h05);
      wr(AR, 8'h07);
      pins(3'h7, 3'h5, 3'h0);
      rd(AD, 3'h5, "latch");
      wr(AR, 8'h00);
      @(posedge clock);
      peerDrive <= 3'h7;
      peerLevel <= 3'h6;
      rd(AD, 3'h6, "pin level");
      $display("plain port test done");
   endtask
   task automatic t_serial();
      @(posedge clock);
      peerDrive <= 3'h2;
      peerLevel <= 3'h2;
      serialDataOutShift <= 1'b1;
      serialClockGenerated <= 1'b0;
      wr(AC, 8'h03);
      pins(3'h5, 3'h1, 3'h0);
      `CHK("dataIn", 1'b1, serialDataInShift)
      `CHK("enable", 1'b1, serialEnableBit)
      `CHK("master", 1'b1, masterSelectBit)
      rd(AC, 3'h3, "control");
      @(posedge clock);
      serialClockGenerated <= 1'b1;
      @(negedge clock);
      `CHK("clockPin", 3'h5, pinOut)
      rd(AD, 3'h7, "serial pins");
      wr(AR, 8'h01);
      wr(AD, 8'h02);
      pins(3'h5, 3'h5, 3'h0);
      rd(AR, 3'h1, "direction");
      rd(AD, 3'h6, "mixed read");
      wr(AC, 8'h01);
      @(posedge clock);
      peerDrive <= 3'h6;
      peerLevel <= 3'h4;
      @(negedge clock);
      pins(3'h1, 3'h1, 3'h0);
      `CHK("clockIn", 1'b1, serialClockIn)
      @(posedge clock);
      peerLevel <= 3'h0;
      @(negedge clock);
      `CHK("clockIn", 1'b0, serialClockIn)
      wr(AC, 8'h00);
      pins(3'h1, 3'h2, 3'h4);
      `CHK("master", 1'b0, masterSelectBit)
      $display("serial test done");
   endtask
   task automatic t_freeze();
      @(posedge clock);
      clockEnable <= 1'b0;
      wr(AR, 8'h07);
      pins(3'h1, 3'h2, 3'h4);
      @(posedge clock);
      clockEnable <= 1'b1;
      rd(AR, 3'h1, "frozen direction");
      $display("freeze test done");
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         conclude();
      end
   end
   initial begin
      {rst, clockEnable, writeStrobe, readStrobe, globalPulldownDisable} = 5'h18;
      {serialDataOutShift, serialClockGenerated, address, writeData} = 12'h000;
      {peerDrive, peerLevel} = 6'h00;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(negedge clock);
      t_plain();
      t_serial();
      t_freeze();
      conclude();
   end
endmodule

// file: hw/port_b_serial_pin_mux.sv
// Pin multiplexer for three port pins shared with a simple serial interface
`timescale 1ns/100ps
module port_b_serial_pin_mux (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   input wire logic clockEnable,
   // Register port
   input wire logic [1:0] address,
   input wire logic [7:0] writeData,
   input wire logic writeStrobe,
   input wire logic readStrobe,
   output logic [7:0] readData,
   // Option bit
   input wire logic globalPulldownDisable,
   // Serial shifter side
   input wire logic serialDataOutShift,
   input wire logic serialClockGenerated,
   output logic serialDataInShift,
   output logic serialClockIn,
   output logic serialEnableBit,
   output logic masterSelectBit,
   // Pins: index 0 pin five, 1 pin six, 2 pin seven
   input wire logic [2:0] pinIn,
   output logic [2:0] pinOut,
   output logic [2:0] pinOe,
   output logic [2:0] pulldownOn
);
   logic [2:0] direction;
   logic [2:0] inhibit;
   logic [2:0] dataLatch;
   logic [1:0] control;
   logic [2:0] readValue;
   logic [7:0] next_readData;

   assign serialEnableBit = control[port_b_serial_pin_mux_pkg::SERIAL_ENABLE_POS];
   assign masterSelectBit = control[port_b_serial_pin_mux_pkg::MASTER_SELECT_POS];

   // Direction register
   always_ff @(posedge clock) begin
      if (rst) begin
         direction <= port_b_serial_pin_mux_pkg::DIRECTION_RESET;
      end else if (clockEnable && writeStrobe &&
                   address == port_b_serial_pin_mux_pkg::ADDR_DIRECTION) begin
         direction <= writeData[2:0];
      end
   end

   // Data latch
   always_ff @(posedge clock) begin
      if (rst) begin
         dataLatch <= port_b_serial_pin_mux_pkg::DATA_RESET;
      end else if (clockEnable && writeStrobe &&
                   address == port_b_serial_pin_mux_pkg::ADDR_DATA) begin
         dataLatch <= writeData[2:0];
      end
   end

   // Pulldown inhibit
   always_ff @(posedge clock) begin
      if (rst) begin
         inhibit <= port_b_serial_pin_mux_pkg::INHIBIT_RESET;
      end else if (clockEnable && writeStrobe &&
                   address == port_b_serial_pin_mux_pkg::ADDR_PULLDOWN_INHIBIT) begin
         inhibit <= writeData[2:0];
      end
   end

   // Serial control
   always_ff @(posedge clock) begin
      if (rst) begin
         control <= port_b_serial_pin_mux_pkg::CONTROL_RESET;
      end else if (clockEnable && writeStrobe &&
                   address == port_b_serial_pin_mux_pkg::ADDR_SERIAL_CONTROL) begin
         control <= writeData[1:0];
      end
   end

   // Pin routing
   always_comb begin
      pinOut = dataLatch;
      pinOe = direction;
      pulldownOn = ~direction & ~inhibit & {3{~globalPulldownDisable}};
      if (serialEnableBit) begin
         pinOut[port_b_serial_pin_mux_pkg::PIN_OUT] = serialDataOutShift;
         pinOe[port_b_serial_pin_mux_pkg::PIN_OUT] = 1'b1;
         pinOut[port_b_serial_pin_mux_pkg::PIN_IN] = 1'b0;
         pinOe[port_b_serial_pin_mux_pkg::PIN_IN] = 1'b0;
         pinOut[port_b_serial_pin_mux_pkg::PIN_CLOCK] =
            masterSelectBit ? serialClockGenerated : 1'b0;
         pinOe[port_b_serial_pin_mux_pkg::PIN_CLOCK] = masterSelectBit;
         pulldownOn = 3'h0;
      end
   end

   // Shifter inputs
   assign serialDataInShift = serialEnableBit & pinIn[port_b_serial_pin_mux_pkg::PIN_IN];
   assign serialClockIn = (serialEnableBit && !masterSelectBit) ?
      pinIn[port_b_serial_pin_mux_pkg::PIN_CLOCK] : 1'b0;

   // Read value per pin
   always_comb begin
      readValue = (direction & dataLatch) | (~direction & pinIn);
      next_readData = 8'h00;
      case (address)
         port_b_serial_pin_mux_pkg::ADDR_DATA: begin
            next_readData = {5'h00, readValue};
         end
         port_b_serial_pin_mux_pkg::ADDR_DIRECTION: begin
            next_readData = {5'h00, direction};
         end
         port_b_serial_pin_mux_pkg::ADDR_PULLDOWN_INHIBIT: begin
            next_readData = {5'h00, inhibit};
         end
         port_b_serial_pin_mux_pkg::ADDR_SERIAL_CONTROL: begin
            next_readData = {6'h00, control};
         end
         default: begin
            next_readData = 8'h00;
         end
      endcase
   end

   // Read data valid in the cycle after an enabled read strobe, held while clockEnable is low
   always_ff @(posedge clock) begin
      if (rst) begin
         readData <= 8'h00;
      end else if (clockEnable) begin
         readData <= readStrobe ? next_readData : 8'h00;
      end
   end

   // Serial ownership of the pins
   chk_data_out_drive: assert property (@(posedge clock) disable iff (rst)
      serialEnableBit |->
      pinOe[0] && pinOut[0] == serialDataOutShift && !pulldownOn[0])
      else $error("data-out pin not driven by shifter");

   chk_data_in_release: assert property (@(posedge clock) disable iff (rst)
      serialEnableBit |->
      !pinOe[1] && !pulldownOn[1] && serialDataInShift == pinIn[1])
      else $error("data-in pin not released");

   chk_clock_master: assert property (@(posedge clock) disable iff (rst)
      serialEnableBit && masterSelectBit |->
      pinOe[2] && pinOut[2] == serialClockGenerated && !pulldownOn[2])
      else $error("clock pin not driven in master mode");

   chk_clock_slave: assert property (@(posedge clock) disable iff (rst)
      serialEnableBit && !masterSelectBit |->
      !pinOe[2] && serialClockIn == pinIn[2] && !pulldownOn[2])
      else $error("clock pin not released in slave mode");

   chk_serial_no_pull: assert property (@(posedge clock) disable iff (rst)
      serialEnableBit |->
      pulldownOn == 3'h0)
      else $error("pulldown on under serial control");

   chk_data_in_idle: assert property (@(posedge clock) disable iff (rst)
      !serialEnableBit |->
      serialDataInShift == 1'b0)
      else $error("shifter input not quiet");

   chk_clock_in_idle: assert property (@(posedge clock) disable iff (rst)
      !(serialEnableBit && !masterSelectBit) |->
      serialClockIn == 1'b0)
      else $error("shift clock input not quiet");

   // Port control and pulldown rules with the serial interface off, and the driven-pin and global pulldown rules in every mode
   chk_idle_pins: assert property (@(posedge clock) disable iff (rst)
      !serialEnableBit |->
      pinOe == direction && pinOut == dataLatch)
      else $error("pins not under port control");

   chk_pulldown_rule: assert property (@(posedge clock) disable iff (rst)
      !serialEnableBit |->
      pulldownOn == (~direction & ~inhibit & {3{~globalPulldownDisable}}))
      else $error("pulldown state wrong");

   chk_output_no_pull: assert property (@(posedge clock) disable iff (rst)
      1'b1 |->
      (pinOe & pulldownOn) == 3'h0)
      else $error("pulldown on at driven pin");

   chk_pull_global: assert property (@(posedge clock) disable iff (rst)
      globalPulldownDisable |->
      pulldownOn == 3'h0)
      else $error("pulldown on while globally disabled");

   chk_pull_inhibit: assert property (@(posedge clock) disable iff (rst)
      !serialEnableBit |->
      (pulldownOn & inhibit) == 3'h0)
      else $error("pulldown on at inhibited pin");

   // Register writes
   chk_latch_write: assert property (@(posedge clock) disable iff (rst)
      clockEnable && writeStrobe &&
      address == port_b_serial_pin_mux_pkg::ADDR_DATA |=>
      dataLatch == $past(writeData[2:0]))
      else $error("data write lost");

   chk_direction_write: assert property (@(posedge clock) disable iff (rst)
      clockEnable && writeStrobe &&
      address == port_b_serial_pin_mux_pkg::ADDR_DIRECTION |=>
      direction == $past(writeData[2:0]))
      else $error("direction write lost");

   chk_inhibit_write: assert property (@(posedge clock) disable iff (rst)
      clockEnable && writeStrobe &&
      address == port_b_serial_pin_mux_pkg::ADDR_PULLDOWN_INHIBIT |=>
      inhibit == $past(writeData[2:0]))
      else $error("inhibit write lost");

   chk_control_write: assert property (@(posedge clock) disable iff (rst)
      clockEnable && writeStrobe &&
      address == port_b_serial_pin_mux_pkg::ADDR_SERIAL_CONTROL |=>
      control == $past(writeData[1:0]))
      else $error("control write lost");

   chk_serial_dir_write: assert property (@(posedge clock) disable iff (rst)
      serialEnableBit && clockEnable && writeStrobe &&
      address == port_b_serial_pin_mux_pkg::ADDR_DIRECTION |=>
      $stable(control))
      else $error("direction write disturbed serial control");

   // Clock enable freeze
   chk_freeze_direction: assert property (@(posedge clock) disable iff (rst)
      !clockEnable |=>
      $stable(direction))
      else $error("direction moved while frozen");

   chk_freeze_latch: assert property (@(posedge clock) disable iff (rst)
      !clockEnable |=>
      $stable(dataLatch))
      else $error("data latch moved while frozen");

   chk_freeze_inhibit: assert property (@(posedge clock) disable iff (rst)
      !clockEnable |=>
      $stable(inhibit))
      else $error("inhibit moved while frozen");

   chk_freeze_control: assert property (@(posedge clock) disable iff (rst)
      !clockEnable |=>
      $stable(control))
      else $error("control moved while frozen");

   chk_freeze_read: assert property (@(posedge clock) disable iff (rst)
      !clockEnable |=>
      $stable(readData))
      else $error("read data moved while frozen");

   // Reads
   chk_read_value: assert property (@(posedge clock) disable iff (rst)
      clockEnable && readStrobe &&
      address == port_b_serial_pin_mux_pkg::ADDR_DATA |=>
      readData[2:0] == (($past(direction) & $past(dataLatch)) |
      (~$past(direction) & $past(pinIn))))
      else $error("data read wrong");

   chk_read_direction: assert property (@(posedge clock) disable iff (rst)
      clockEnable && readStrobe &&
      address == port_b_serial_pin_mux_pkg::ADDR_DIRECTION |=>
      readData == {5'h00, $past(direction)})
      else $error("direction read wrong");

   chk_read_inhibit: assert property (@(posedge clock) disable iff (rst)
      clockEnable && readStrobe &&
      address == port_b_serial_pin_mux_pkg::ADDR_PULLDOWN_INHIBIT |=>
      readData == {5'h00, $past(inhibit)})
      else $error("inhibit read wrong");

   chk_read_control: assert property (@(posedge clock) disable iff (rst)
      clockEnable && readStrobe &&
      address == port_b_serial_pin_mux_pkg::ADDR_SERIAL_CONTROL |=>
      readData == {6'h00, $past(control)})
      else $error("control read wrong");

   chk_read_upper: assert property (@(posedge clock) disable iff (rst)
      clockEnable && readStrobe |=>
      readData[7:3] == 5'h00)
      else $error("unused read bits set");

   chk_read_idle: assert property (@(posedge clock) disable iff (rst)
      clockEnable && !readStrobe |=>
      readData == 8'h00)
      else $error("read data outside read cycle");

   // Reset state
   chk_reset_state: assert property (@(posedge clock) disable iff (rst)
      $fell(rst) |->
      direction == port_b_serial_pin_mux_pkg::DIRECTION_RESET &&
      control == port_b_serial_pin_mux_pkg::CONTROL_RESET)
      else $error("registers not cleared by reset");

   chk_reset_read: assert property (@(posedge clock) disable iff (rst)
      $fell(rst) |->
      readData == 8'h00)
      else $error("read data not cleared by reset");

   cov_master: cover property (@(posedge clock) disable iff (rst)
      serialEnableBit && masterSelectBit);
   cov_slave: cover property (@(posedge clock) disable iff (rst)
      serialEnableBit && !masterSelectBit);
   cov_release: cover property (@(posedge clock) disable iff (rst)
      serialEnableBit ##1 !serialEnableBit);
   cov_pulled: cover property (@(posedge clock) disable iff (rst)
      pulldownOn != 3'h0);
   cov_frozen: cover property (@(posedge clock) disable iff (rst)
      !clockEnable && writeStrobe);
endmodule

// file: hw/port_b_serial_pin_mux_pkg.sv
// Constants for the upper port pin multiplexer
package port_b_serial_pin_mux_pkg;
   localparam logic [1:0] ADDR_DATA = 2'h0;
   localparam logic [1:0] ADDR_DIRECTION = 2'h1;
   localparam logic [1:0] ADDR_PULLDOWN_INHIBIT = 2'h2;
   localparam logic [1:0] ADDR_SERIAL_CONTROL = 2'h3;
   localparam int SHARED_PINS = 3;
   localparam int PIN_OUT = 0;
   localparam int PIN_IN = 1;
   localparam int PIN_CLOCK = 2;
   localparam int SERIAL_ENABLE_POS = 0;
   localparam int MASTER_SELECT_POS = 1;
   localparam logic [2:0] DIRECTION_RESET = 3'h0;
   localparam logic [2:0] INHIBIT_RESET = 3'h0;
   localparam logic [2:0] DATA_RESET = 3'h0;
   localparam logic [1:0] CONTROL_RESET = 2'h0;
endpackage
